/* hw/mcu_decoder_regs.svh */
// Behaviour
// - Every file-register instruction reads the register first, even pure writes.
// - Port registers modified from themselves take their value from the pin levels.
// - Byte destination bit clear sends result to accumulator, set sends it to register.
// - Register address operand is seven bits, selecting 0x00 to 0x7f.
// - Bit index selects one of eight bits of the addressed register.
// - Don't-care instruction bits never change the decoded operation.
// - Byte words: 00, code, dest, address; 0001 and 0000 split by dest.
// - Byte OR, AND, XOR with accumulator update only the zero flag.
// - Register and literal add and subtract update carry, digit carry and zero.
// - Rotates pass bits through carry and update only carry.
// - Decrement/increment set zero; skip forms change no flag, skip on zero.
// - Bit words: 01, op, index, address; clear, set, two tests; no flags.
// - Bit test takes one cycle, two with a no-operation when it skips.
// - Literal OR, AND, XOR with accumulator update only zero, one cycle.
// - Literal load one cycle; return-with-literal loads, returns, two cycles; no flags.
// - Call, jump, return and interrupt return take two cycles, second a no-op.
// - Watchdog clear and standby entry take one cycle and update time-out, power-down.
// - Writing the timer counter register clears the prescaler when assigned to it.
// - One instruction cycle spans four oscillator periods.
`ifndef MCU_DECODER_REGS_SVH
`define MCU_DECODER_REGS_SVH

// APB register byte offsets
`define OFS_CTRL 12'h000
`define OFS_ACC 12'h004
`define OFS_FLAGS 12'h008
`define OFS_LASTOP 12'h00c

// Control register bits and reset values
`define CTRL_RUN 0
`define CTRL_PRESC 1
`define RUN_RST 1'b1
`define PRESC_RST 1'b0

// Flag register bit positions and reset values
`define FLG_C 0
`define FLG_DC 1
`define FLG_Z 2
`define FLG_POWERDOWN 3
`define FLG_TIMEOUT 4
`define TIMEOUT_RST 1'b1
`define POWERDOWN_RST 1'b1

// Instruction word fields
`define F_CLASS 13:12
`define F_BYTEOP 11:8
`define F_DEST 7
`define F_ADDR 6:0
`define F_BITOP 11:10
`define F_BITIDX 9:7
`define F_LIT8 7:0
`define F_LIT11 10:0
`define F_JMPSEL 11
`define F_LIT_LO 4:0
`define F_LASTOP 19:14

// Control words within the 0000 byte group
`define W_RETURN 8'h08
`define W_INTRET 8'h09
`define W_WDTCLR 8'h64
`define W_SLEEP 8'h63

// Instruction cycle phases, four oscillator periods
`define PH_READ 2'h0
`define PH_LATCH 2'h1
`define PH_EXEC 2'h2
`define PH_FETCH 2'h3

`endif

/* hw/mcu_decoder_pkg.sv */
package mcu_decoder_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_ACC_TO_REG_MOVE, OP_RETURN, OP_INTERRUPT_RETURN, OP_WATCHDOG_CLEAR,
    OP_STANDBY, OP_REG_CLEAR, OP_ACC_CLEAR, OP_SUB_ACC_FROM_REG, OP_REG_DECREMENT,
    OP_OR_ACC_WITH_REG, OP_AND_ACC_WITH_REG, OP_XOR_ACC_WITH_REG, OP_ADD_ACC_TO_REG,
    OP_REG_MOVE, OP_REG_COMPLEMENT, OP_REG_INCREMENT, OP_REG_DECREMENT_SKIP_ZERO,
    OP_ROTATE_RIGHT_CARRY, OP_ROTATE_LEFT_CARRY, OP_NIBBLE_EXCHANGE,
    OP_REG_INCREMENT_SKIP_ZERO, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TEST_SKIP_CLEAR,
    OP_BIT_TEST_SKIP_SET, OP_CALL, OP_JUMP, OP_LITERAL_LOAD_ACC, OP_RETURN_WITH_LITERAL,
    OP_OR_LITERAL_ACC, OP_AND_LITERAL_ACC, OP_XOR_LITERAL_ACC, OP_SUB_ACC_FROM_LITERAL,
    OP_ADD_LITERAL_ACC
  } op_t;

  // Read-modify-write request to the file register array
  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [6:0] addr;
    logic [7:0] wrData;
  } file_req_t;

  // Program counter and stack requests
  typedef struct packed {
    logic pcLoad;
    logic pcPush;
    logic pcPop;
    logic intReturn;
    logic [10:0] target;
  } flow_ctl_t;

  typedef struct packed {
    logic [1:0] phase;
    logic [13:0] instr;
    logic [7:0] rdVal;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic timeoutFlag;
    logic powerdownFlag;
    logic flush;
    logic nopCycle;
    logic instrDone;
    logic prescClr;
    logic wdtClr;
    logic sleepReq;
    logic ctrlRun;
    logic ctrlPresc;
    logic [7:0] pinS1;
    logic [7:0] pinS2;
    logic [7:0] pinS3;
    logic [7:0] pinStable;
    file_req_t fileReq;
    flow_ctl_t flow;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

endpackage

/* hw/mcu_instruction_decoder.sv */
`timescale 1ns/1ps
`include "mcu_decoder_regs.svh"

module mcu_instruction_decoder #(
  parameter logic [6:0] TIMER_ADDR = 7'h01,
  parameter logic [6:0] IO_ADDR_A = 7'h05,
  parameter logic [6:0] IO_ADDR_B = 7'h06
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [13:0] progWord,
  input wire logic [7:0] fileRdData,
  input wire logic [7:0] pinLevel,
  output mcu_decoder_pkg::file_req_t fileReq,
  output mcu_decoder_pkg::flow_ctl_t flowCtl,
  output logic instrDone,
  output logic nopCycle,
  output logic prescClr,
  output logic wdtClr,
  output logic sleepReq
);
  import mcu_decoder_pkg::*;

  state_t s_q;
  state_t s_d;
  op_t op;
  logic [7:0] aluRes;
  logic [9:0] sum;
  logic [7:0] bitSel;
  logic toFile;
  logic toAcc;
  logic destOp;
  logic updZ;
  logic updCarry;
  logic skip;
  logic pcChange;

  // Full decode of one word; x positions never looked at
  function automatic op_t decodeOp(input logic [13:0] w);
    op_t o;
    o = OP_NOP;
    case (w[`F_CLASS])
      2'h0: begin
        case (w[`F_BYTEOP])
          4'h0: begin
            if (w[`F_DEST]) o = OP_ACC_TO_REG_MOVE;
            else if (w[`F_LIT8] == `W_RETURN) o = OP_RETURN;
            else if (w[`F_LIT8] == `W_INTRET) o = OP_INTERRUPT_RETURN;
            else if (w[`F_LIT8] == `W_WDTCLR) o = OP_WATCHDOG_CLEAR;
            else if (w[`F_LIT8] == `W_SLEEP) o = OP_STANDBY;
            else o = OP_NOP;
          end
          4'h1: o = w[`F_DEST] ? OP_REG_CLEAR : OP_ACC_CLEAR;
          4'h2: o = OP_SUB_ACC_FROM_REG;
          4'h3: o = OP_REG_DECREMENT;
          4'h4: o = OP_OR_ACC_WITH_REG;
          4'h5: o = OP_AND_ACC_WITH_REG;
          4'h6: o = OP_XOR_ACC_WITH_REG;
          4'h7: o = OP_ADD_ACC_TO_REG;
          4'h8: o = OP_REG_MOVE;
          4'h9: o = OP_REG_COMPLEMENT;
          4'ha: o = OP_REG_INCREMENT;
          4'hb: o = OP_REG_DECREMENT_SKIP_ZERO;
          4'hc: o = OP_ROTATE_RIGHT_CARRY;
          4'hd: o = OP_ROTATE_LEFT_CARRY;
          4'he: o = OP_NIBBLE_EXCHANGE;
          default: o = OP_REG_INCREMENT_SKIP_ZERO;
        endcase
      end
      2'h1: begin
        case (w[`F_BITOP])
          2'h0: o = OP_BIT_CLEAR;
          2'h1: o = OP_BIT_SET;
          2'h2: o = OP_BIT_TEST_SKIP_CLEAR;
          default: o = OP_BIT_TEST_SKIP_SET;
        endcase
      end
      2'h2: o = w[`F_JMPSEL] ? OP_JUMP : OP_CALL;
      default: begin
        casez (w[`F_BYTEOP])
          4'b00??: o = OP_LITERAL_LOAD_ACC;
          4'b01??: o = OP_RETURN_WITH_LITERAL;
          4'b1000: o = OP_OR_LITERAL_ACC;
          4'b1001: o = OP_AND_LITERAL_ACC;
          4'b1010: o = OP_XOR_LITERAL_ACC;
          4'b110?: o = OP_SUB_ACC_FROM_LITERAL;
          4'b111?: o = OP_ADD_LITERAL_ACC;
          default: o = OP_NOP;
        endcase
      end
    endcase
    return o;
  endfunction

  // Adder giving carry, digit carry and sum
  function automatic logic [9:0] addc(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction

  // Instructions that name a file register
  function automatic logic namesFile(input logic [13:0] w, input op_t o);
    return (w[`F_CLASS] == 2'h1) || ((w[`F_CLASS] == 2'h0) && (o != OP_NOP) &&
      (o != OP_ACC_CLEAR) && (o != OP_RETURN) && (o != OP_INTERRUPT_RETURN) &&
      (o != OP_WATCHDOG_CLEAR) && (o != OP_STANDBY));
  endfunction

  // Next state: phase sequencing, execution, pin sync, APB slave
  always_comb begin
    s_d = s_q;
    op = decodeOp(s_q.instr);
    bitSel = 8'h01 << s_q.instr[`F_BITIDX];
    sum = addc((s_q.instr[`F_CLASS] == 2'h3) ? s_q.instr[`F_LIT8] : s_q.rdVal,
      ((op == OP_SUB_ACC_FROM_REG) || (op == OP_SUB_ACC_FROM_LITERAL)) ? ~s_q.acc : s_q.acc,
      (op == OP_SUB_ACC_FROM_REG) || (op == OP_SUB_ACC_FROM_LITERAL));
    aluRes = s_q.rdVal;
    toFile = 1'b0;
    toAcc = 1'b0;
    destOp = 1'b0;
    updZ = 1'b0;
    updCarry = 1'b0;
    skip = 1'b0;
    pcChange = 1'b0;
    case (op)
      OP_ACC_TO_REG_MOVE: begin
        aluRes = s_q.acc;
        toFile = 1'b1;
      end
      OP_REG_CLEAR: begin
        aluRes = 8'h00;
        toFile = 1'b1;
        updZ = 1'b1;
      end
      OP_ACC_CLEAR: begin
        aluRes = 8'h00;
        toAcc = 1'b1;
        updZ = 1'b1;
      end
      OP_ADD_ACC_TO_REG, OP_SUB_ACC_FROM_REG: begin
        aluRes = sum[7:0];
        destOp = 1'b1;
        updZ = 1'b1;
        updCarry = 1'b1;
      end
      OP_OR_ACC_WITH_REG: begin
        aluRes = s_q.rdVal | s_q.acc;
        destOp = 1'b1;
        updZ = 1'b1;
      end
      OP_AND_ACC_WITH_REG: begin
        aluRes = s_q.rdVal & s_q.acc;
        destOp = 1'b1;
        updZ = 1'b1;
      end
      OP_XOR_ACC_WITH_REG: begin
        aluRes = s_q.rdVal ^ s_q.acc;
        destOp = 1'b1;
        updZ = 1'b1;
      end
      OP_REG_DECREMENT, OP_REG_INCREMENT: begin
        aluRes = (op == OP_REG_INCREMENT) ? s_q.rdVal + 8'h01 : s_q.rdVal - 8'h01;
        destOp = 1'b1;
        updZ = 1'b1;
      end
      OP_REG_DECREMENT_SKIP_ZERO, OP_REG_INCREMENT_SKIP_ZERO: begin
        aluRes = (op == OP_REG_INCREMENT_SKIP_ZERO) ? s_q.rdVal + 8'h01 : s_q.rdVal - 8'h01;
        destOp = 1'b1;
        skip = (aluRes == 8'h00);
      end
      OP_REG_MOVE, OP_REG_COMPLEMENT: begin
        aluRes = (op == OP_REG_COMPLEMENT) ? ~s_q.rdVal : s_q.rdVal;
        destOp = 1'b1;
        updZ = 1'b1;
      end
      OP_NIBBLE_EXCHANGE: begin
        aluRes = {s_q.rdVal[3:0], s_q.rdVal[7:4]};
        destOp = 1'b1;
      end
      OP_ROTATE_LEFT_CARRY: begin
        aluRes = {s_q.rdVal[6:0], s_q.c};
        destOp = 1'b1;
      end
      OP_ROTATE_RIGHT_CARRY: begin
        aluRes = {s_q.c, s_q.rdVal[7:1]};
        destOp = 1'b1;
      end
      OP_BIT_CLEAR: begin
        aluRes = s_q.rdVal & ~bitSel;
        toFile = 1'b1;
      end
      OP_BIT_SET: begin
        aluRes = s_q.rdVal | bitSel;
        toFile = 1'b1;
      end
      OP_BIT_TEST_SKIP_CLEAR: skip = ((s_q.rdVal & bitSel) == 8'h00);
      OP_BIT_TEST_SKIP_SET: skip = ((s_q.rdVal & bitSel) != 8'h00);
      OP_LITERAL_LOAD_ACC, OP_RETURN_WITH_LITERAL: begin
        aluRes = s_q.instr[`F_LIT8];
        toAcc = 1'b1;
        pcChange = (op == OP_RETURN_WITH_LITERAL);
      end
      OP_OR_LITERAL_ACC, OP_AND_LITERAL_ACC, OP_XOR_LITERAL_ACC: begin
        aluRes = (op == OP_OR_LITERAL_ACC) ? s_q.instr[`F_LIT8] | s_q.acc :
          (op == OP_AND_LITERAL_ACC) ? s_q.instr[`F_LIT8] & s_q.acc :
          s_q.instr[`F_LIT8] ^ s_q.acc;
        toAcc = 1'b1;
        updZ = 1'b1;
      end
      OP_ADD_LITERAL_ACC, OP_SUB_ACC_FROM_LITERAL: begin
        aluRes = sum[7:0];
        toAcc = 1'b1;
        updZ = 1'b1;
        updCarry = 1'b1;
      end
      OP_CALL, OP_JUMP, OP_RETURN, OP_INTERRUPT_RETURN: pcChange = 1'b1;
      default: aluRes = s_q.rdVal;
    endcase
    // Byte destination select
    if (destOp) begin
      toFile = s_q.instr[`F_DEST];
      toAcc = !s_q.instr[`F_DEST];
    end

    // Pulses last one cycle
    s_d.instrDone = 1'b0;
    s_d.prescClr = 1'b0;
    s_d.wdtClr = 1'b0;
    s_d.sleepReq = 1'b0;
    s_d.fileReq.rdEn = 1'b0;
    s_d.fileReq.wrEn = 1'b0;
    s_d.flow.pcLoad = 1'b0;
    s_d.flow.pcPush = 1'b0;
    s_d.flow.pcPop = 1'b0;
    s_d.flow.intReturn = 1'b0;

    // Pin synchroniser, accepted when stages two and three agree
    s_d.pinS1 = pinLevel;
    s_d.pinS2 = s_q.pinS1;
    s_d.pinS3 = s_q.pinS2;
    if (s_q.pinS2 == s_q.pinS3) s_d.pinStable = s_q.pinS3;

    // Four-phase instruction cycle
    s_d.phase = s_q.phase + 2'h1;
    case (s_q.phase)
      `PH_READ: begin
        s_d.fileReq.rdEn = namesFile(s_q.instr, op);
        s_d.fileReq.addr = s_q.instr[`F_ADDR];
      end
      `PH_LATCH: begin
        if ((s_q.fileReq.addr == IO_ADDR_A) || (s_q.fileReq.addr == IO_ADDR_B))
          s_d.rdVal = s_q.pinStable;
        else
          s_d.rdVal = fileRdData;
      end
      `PH_EXEC: begin
        s_d.instrDone = 1'b1;
        if (toFile) begin
          s_d.fileReq.wrEn = 1'b1;
          s_d.fileReq.wrData = aluRes;
          s_d.prescClr = (s_q.fileReq.addr == TIMER_ADDR) && s_q.ctrlPresc;
        end
        if (toAcc) s_d.acc = aluRes;
        if (updZ) s_d.z = (aluRes == 8'h00);
        if (updCarry) begin
          s_d.c = sum[9];
          s_d.dc = sum[8];
        end
        if (op == OP_ROTATE_LEFT_CARRY) s_d.c = s_q.rdVal[7];
        if (op == OP_ROTATE_RIGHT_CARRY) s_d.c = s_q.rdVal[0];
        if (op == OP_WATCHDOG_CLEAR) begin
          s_d.timeoutFlag = 1'b1;
          s_d.powerdownFlag = 1'b1;
          s_d.wdtClr = 1'b1;
        end
        if (op == OP_STANDBY) begin
          s_d.timeoutFlag = 1'b1;
          s_d.powerdownFlag = 1'b0;
          s_d.sleepReq = 1'b1;
        end
        s_d.flow.pcLoad = (op == OP_CALL) || (op == OP_JUMP);
        s_d.flow.pcPush = (op == OP_CALL);
        s_d.flow.pcPop = (op == OP_RETURN) || (op == OP_INTERRUPT_RETURN) ||
          (op == OP_RETURN_WITH_LITERAL);
        s_d.flow.intReturn = (op == OP_INTERRUPT_RETURN);
        s_d.flow.target = s_q.instr[`F_LIT11];
        s_d.flush = skip || pcChange;
      end
      `PH_FETCH: begin
        // Discarded word becomes a no-operation cycle
        s_d.instr = (s_q.flush || !s_q.ctrlRun) ? 14'h0000 : progWord;
        s_d.nopCycle = s_q.flush;
        s_d.flush = 1'b0;
      end
      default: s_d.phase = `PH_READ;
    endcase

    // APB slave: answer decided in setup, write at access completion
    s_d.pready = psel && !penable;
    s_d.pslverr = 1'b0;
    if (psel && !penable) begin
      s_d.prdata = 32'h00000000;
      case (paddr)
        `OFS_CTRL: begin
          s_d.prdata[`CTRL_RUN] = s_q.ctrlRun;
          s_d.prdata[`CTRL_PRESC] = s_q.ctrlPresc;
        end
        `OFS_ACC: s_d.prdata[7:0] = s_q.acc;
        `OFS_FLAGS: begin
          s_d.prdata[`FLG_C] = s_q.c;
          s_d.prdata[`FLG_DC] = s_q.dc;
          s_d.prdata[`FLG_Z] = s_q.z;
          s_d.prdata[`FLG_POWERDOWN] = s_q.powerdownFlag;
          s_d.prdata[`FLG_TIMEOUT] = s_q.timeoutFlag;
        end
        `OFS_LASTOP: begin
          s_d.prdata[13:0] = s_q.instr;
          s_d.prdata[`F_LASTOP] = op;
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s_q.pready && pwrite) begin
      if (paddr == `OFS_CTRL) begin
        s_d.ctrlRun = pwdata[`CTRL_RUN];
        s_d.ctrlPresc = pwdata[`CTRL_PRESC];
      end
      if (paddr == `OFS_ACC) s_d.acc = pwdata[7:0];
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.timeoutFlag <= `TIMEOUT_RST;
      s_q.powerdownFlag <= `POWERDOWN_RST;
      s_q.ctrlRun <= `RUN_RST;
      s_q.ctrlPresc <= `PRESC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign fileReq = s_q.fileReq;
  assign flowCtl = s_q.flow;
  assign instrDone = s_q.instrDone;
  assign nopCycle = s_q.nopCycle;
  assign prescClr = s_q.prescClr;
  assign wdtClr = s_q.wdtClr;
  assign sleepReq = s_q.sleepReq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Checks
  property p_rmw;
    fileReq.wrEn |-> $past(fileReq.rdEn, 2) && ($past(fileReq.addr, 2) == fileReq.addr);
  endproperty
  a_rmw: assert property (p_rmw) else $error("write without prior read");

  property p_cycle;
    instrDone |=> !instrDone [*3] ##1 instrDone;
  endproperty
  a_cycle: assert property (p_cycle) else $error("instruction cycle not four clocks");

  property p_dest;
    (s_q.phase == `PH_EXEC) && (s_q.instr[`F_CLASS] == 2'h0) && !s_q.instr[`F_DEST]
      |=> !fileReq.wrEn;
  endproperty
  a_dest: assert property (p_dest) else $error("dest clear wrote a register");

  property p_logic_z;
    (s_q.phase == `PH_EXEC) && ((op == OP_OR_ACC_WITH_REG) || (op == OP_AND_ACC_WITH_REG) ||
      (op == OP_XOR_ACC_WITH_REG)) |=> $stable(s_q.c) && $stable(s_q.dc) &&
      (s_q.z == ((($past(op) == OP_OR_ACC_WITH_REG) ? ($past(s_q.rdVal) | $past(s_q.acc)) :
      ($past(op) == OP_AND_ACC_WITH_REG) ? ($past(s_q.rdVal) & $past(s_q.acc)) :
      ($past(s_q.rdVal) ^ $past(s_q.acc))) == 8'h00)) && (s_q.z == $past(aluRes == 8'h00));
  endproperty
  a_logic_z: assert property (p_logic_z) else $error("logic op flag update wrong");

  property p_skip_zero;
    (s_q.phase == `PH_EXEC) && ((op == OP_REG_DECREMENT_SKIP_ZERO) ||
      (op == OP_REG_INCREMENT_SKIP_ZERO)) && (aluRes == 8'h00) |-> ##2 nopCycle [*4];
  endproperty
  a_skip_zero: assert property (p_skip_zero) else $error("zero result did not skip");

  property p_test_noskip;
    (s_q.phase == `PH_EXEC) && (op == OP_BIT_TEST_SKIP_SET) &&
      ((s_q.rdVal & bitSel) == 8'h00) |-> ##2 !nopCycle [*4];
  endproperty
  a_test_noskip: assert property (p_test_noskip) else $error("false test skipped");

  property p_branch;
    flowCtl.pcLoad |-> ##1 nopCycle [*4];
  endproperty
  a_branch: assert property (p_branch) else $error("branch lacks second cycle");

  property p_standby;
    (s_q.phase == `PH_EXEC) && (op == OP_STANDBY) |=> s_q.timeoutFlag &&
      !s_q.powerdownFlag && sleepReq;
  endproperty
  a_standby: assert property (p_standby) else $error("standby flags wrong");

  property p_presc;
    prescClr |-> fileReq.wrEn && (fileReq.addr == TIMER_ADDR) && s_q.ctrlPresc;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler clear without timer write");

endmodule // mcu_instruction_decoder

/* test/prog_mem_model.sv */
`timescale 1ns/1ps
// Program memory and file register array on the far side of the decoder
module prog_mem_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instrDone,
  input wire mcu_decoder_pkg::file_req_t fileReq,
  output logic [13:0] progWord,
  output logic [7:0] fileRdData
);
  import mcu_decoder_pkg::*;
  logic [7:0] regs [128];
  logic busy = 1'b0;
  int rdCount = 0;
  // Idle memory offers the no-operation word
  initial begin
    progWord = 14'h0000;
    foreach (regs[i]) regs[i] = 8'h00;
  end
  // Read data valid only while the read strobe is up, scrambled otherwise
  assign fileRdData = fileReq.rdEn ? regs[fileReq.addr] : ~regs[fileReq.addr];
  // Offer one word, taken at the edge that ends an instruction cycle
  task load(input logic [13:0] w);
    progWord = w;
    busy = 1'b1;
  endtask
  // Count reads, store writes, retire the offered word
  always @(posedge clk_sys) begin
    if (fileReq.rdEn && nrst) rdCount <= rdCount + 1;
    if (fileReq.wrEn) regs[fileReq.addr] <= fileReq.wrData;
    if (instrDone && busy) begin
      busy <= 1'b0;
      progWord <= 14'h0000;
    end
  end
endmodule // prog_mem_model

/* test/test_mcu_instruction_decoder.sv */
`timescale 1ns/1ps
`include "mcu_decoder_regs.svh"
module test_mcu_instruction_decoder;
  import mcu_decoder_pkg::*;
  typedef struct packed {
    logic [13:0] w;
    logic [7:0] a;
    logic [7:0] r;
    logic [7:0] ea;
    logic [7:0] er;
    logic [4:0] ef;
    logic [7:0] x;
  } step_t;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
  logic instrDone, nopCycle, prescClr, wdtClr, sleepReq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [13:0] progWord;
  logic [7:0] fileRdData, pinLevel;
  logic [6:0] evSeen = 7'h00;
  file_req_t fileReq;
  flow_ctl_t flowCtl;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int waited;
  logic [10:0] tgtSeen = 11'h000;
  // Word, acc in, reg in, acc out, reg out, flags {timeout,powerdown,z,dc,c}, {skip, events}
  step_t steps [39] = '{
    '{14'h07a0,8'h0f,8'hf1,8'h0f,8'h00,5'h1f,8'h00},
    '{14'h0420,8'h50,8'h0a,8'h5a,8'h0a,5'h1b,8'h00},
    '{14'h05a0,8'hf0,8'h0f,8'hf0,8'h00,5'h1f,8'h00},
    '{14'h0620,8'hff,8'h0f,8'hf0,8'h0f,5'h1b,8'h00},
    '{14'h0220,8'h01,8'h10,8'h0f,8'h10,5'h19,8'h00},
    '{14'h02a0,8'h01,8'h00,8'h01,8'hff,5'h18,8'h00},
    '{14'h0da0,8'h33,8'h81,8'h33,8'h02,5'h19,8'h00},
    '{14'h0c20,8'h00,8'h02,8'h81,8'h02,5'h18,8'h00},
    '{14'h03a0,8'h00,8'h01,8'h00,8'h00,5'h1c,8'h00},
    '{14'h0a20,8'h00,8'h10,8'h11,8'h10,5'h18,8'h00},
    '{14'h0820,8'h77,8'h00,8'h00,8'h00,5'h1c,8'h00},
    '{14'h09a0,8'h00,8'h5a,8'h00,8'ha5,5'h18,8'h00},
    '{14'h017f,8'h44,8'h12,8'h00,8'h12,5'h1c,8'h00},
    '{14'h0e20,8'h00,8'h3c,8'hc3,8'h3c,5'h1c,8'h00},
    '{14'h01a0,8'h55,8'h77,8'h55,8'h00,5'h1c,8'h00},
    '{14'h00a0,8'h99,8'h12,8'h99,8'h99,5'h1c,8'h00},
    '{14'h0060,8'h21,8'h34,8'h21,8'h34,5'h1c,8'h00},
    '{14'h3355,8'h00,8'h00,8'h55,8'h00,5'h1c,8'h00},
    '{14'h380f,8'hf0,8'h00,8'hff,8'h00,5'h18,8'h00},
    '{14'h3900,8'hff,8'h00,8'h00,8'h00,5'h1c,8'h00},
    '{14'h3aff,8'h0f,8'h00,8'hf0,8'h00,5'h18,8'h00},
    '{14'h3f01,8'hff,8'h00,8'h00,8'h00,5'h1f,8'h00},
    '{14'h3c05,8'h06,8'h00,8'hff,8'h00,5'h18,8'h00},
    '{14'h11a0,8'h00,8'hff,8'h00,8'hf7,5'h18,8'h00},
    '{14'h17a0,8'h00,8'h00,8'h00,8'h80,5'h18,8'h00},
    '{14'h1820,8'h00,8'hfe,8'h00,8'hfe,5'h18,8'h80},
    '{14'h1fa0,8'h00,8'h7f,8'h00,8'h7f,5'h18,8'h00},
    '{14'h0ba0,8'h00,8'h01,8'h00,8'h00,5'h18,8'h80},
    '{14'h0f20,8'h00,8'h05,8'h06,8'h05,5'h18,8'h00},
    '{14'h3442,8'h00,8'h00,8'h42,8'h00,5'h18,8'h84},
    '{14'h2123,8'h00,8'h00,8'h00,8'h00,5'h18,8'h83},
    '{14'h2d55,8'h00,8'h00,8'h00,8'h00,5'h18,8'h81},
    '{14'h0008,8'h00,8'h00,8'h00,8'h00,5'h18,8'h84},
    '{14'h0009,8'h00,8'h00,8'h00,8'h00,5'h18,8'h8c},
    '{14'h0063,8'h00,8'h00,8'h00,8'h00,5'h10,8'h40},
    '{14'h0064,8'h00,8'h00,8'h00,8'h00,5'h18,8'h20},
    '{14'h0181,8'h00,8'h33,8'h00,8'h00,5'h1c,8'h10},
    '{14'h0801,8'h00,8'h00,8'h00,8'h00,5'h1c,8'h00},
    '{14'h0885,8'h00,8'h00,8'h00,8'ha5,5'h18,8'h00}
  };

  mcu_instruction_decoder dut (
    .clk_sys(clk_sys), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progWord(progWord), .fileRdData(fileRdData), .pinLevel(pinLevel), .fileReq(fileReq),
    .flowCtl(flowCtl), .instrDone(instrDone), .nopCycle(nopCycle), .prescClr(prescClr),
    .wdtClr(wdtClr), .sleepReq(sleepReq)
  );

  prog_mem_model pm (
    .clk_sys(clk_sys), .nrst(nrst), .instrDone(instrDone), .fileReq(fileReq),
    .progWord(progWord), .fileRdData(fileRdData)
  );

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Gather strobes and flow pulses of the step in flight; cut a hang short
  always @(posedge clk_sys) begin
    evSeen <= evSeen | {sleepReq, wdtClr, prescClr, flowCtl.intReturn, flowCtl.pcPop,
                        flowCtl.pcPush, flowCtl.pcLoad};
    if (flowCtl.pcLoad === 1'b1) tgtSeen <= flowCtl.target;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One bus transfer; read data and error taken at the pready edge
  task apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for the end-of-cycle strobe, counting clocks
  task wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (instrDone !== 1'b1 && n < 64);
  endtask

  // Preset, execute one word, then check every result
  task run_step(input step_t s);
    int n;
    int rd0;
    int rdx;
    rdx = (s.w[13:12] == 2'b01 || (s.w[13:12] == 2'b00 && (s.w[11:9] != 3'b000 || s.w[7])));
    apb(`OFS_ACC, 1'b1, {24'h0, s.a});
    @(negedge clk_sys);
    pm.regs[s.w[6:0]] = s.r;
    rd0 = pm.rdCount;
    evSeen = 7'h00;
    pm.load(s.w);
    n = 0;
    while (pm.busy && n < 64) begin
      @(negedge clk_sys);
      n++;
    end
    wait_done(n);
    wait_done(n);
    cmp_word(n, 4);
    cmp_bit(nopCycle, s.x[7]);
    cmp_word(pm.rdCount - rd0, rdx);
    cmp_word({25'h0, evSeen}, {25'h0, s.x[6:0]});
    if (s.x[0]) cmp_word({21'h0, tgtSeen}, {21'h0, s.w[10:0]});
    cmp_word({24'h0, pm.regs[s.w[6:0]]}, {24'h0, s.er});
    apb(`OFS_ACC, 1'b0, 32'h0);
    cmp_word(q, {24'h0, s.ea});
    apb(`OFS_FLAGS, 1'b0, 32'h0);
    cmp_word(q, {27'h0, s.ef});
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pinLevel = 8'ha5;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(`OFS_CTRL, 1'b0, 32'h0);
    cmp_word(q, 32'h1);
    apb(`OFS_FLAGS, 1'b1, 32'h0);
    apb(`OFS_FLAGS, 1'b0, 32'h0);
    cmp_word(q, 32'h18);
    apb(12'h010, 1'b0, 32'h0);
    cmp_bit(e, 1'b1);
    apb(`OFS_LASTOP, 1'b0, 32'h0);
    cmp_word(q, {12'h000, OP_NOP, 14'h0000});
    apb(`OFS_CTRL, 1'b1, 32'h0);
    @(negedge clk_sys);
    pm.load(14'h3377);
    while (pm.busy) @(negedge clk_sys);
    wait_done(waited);
    wait_done(waited);
    apb(`OFS_ACC, 1'b0, 32'h0);
    cmp_word(q, 32'h0);
    $display("halt test done");
    apb(`OFS_CTRL, 1'b1, 32'h3);
    apb(`OFS_CTRL, 1'b0, 32'h0);
    cmp_word(q, 32'h3);
    $display("register test done");
    foreach (steps[i]) run_step(steps[i]);
    $display("instruction test done");
    tally_and_finish();
  end
endmodule // test_mcu_instruction_decoder
